// ===== hdl/dsd_decoder.sv
// Purpose: data space decoder with io, sram and eeprom access
// Assumes: one request at a time, taken while o_ready is high
// Notes:   unlisted io addresses go to the peripheral port
`timescale 1ns/1ps
`include "dsd_cfg.svh"
module dsd_decoder #(
  parameter int EE_WR_CYCLES = `DSD_EE_WR_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  input  dsd_pkg::dsd_req_s        i_req,
  output logic                     o_ready,
  output dsd_pkg::dsd_rsp_s        o_rsp,
  output dsd_pkg::dsd_region_t     o_region,
  output dsd_pkg::dsd_periph_s     o_periph,
  input  wire logic [7:0]          i_periph_rdata,
  input  wire logic [7:0]          i_status_evt,
  output logic                     o_ee_busy
);
  import dsd_pkg::*;
  typedef enum logic {ST_IDLE, ST_SRAM} dsd_state_e;

  dsd_state_e        state_q;
  logic [7:0]        rf_q [32];
  logic [7:0]        sram_q [`DSD_SRAM_BYTES];
  logic [7:0]        ee_mem_q [`DSD_EE_BYTES];
  logic [7:0]        gpio_q [3];
  logic [7:0]        status_q;
  logic [2:0]        stall_q;
  logic              mpe_q;
  logic [2:0]        mpe_cnt_q;
  logic              pe_q;
  logic [19:0]       wr_cnt_q;
  logic [11:0]       ee_addr_q;
  logic [7:0]        ee_data_q;
  logic [`DSD_EE_AW-1:0] wr_addr_q;
  logic [7:0]        wr_data_q;
  logic [`DSD_SRAM_AW-1:0] s_idx_q;
  logic              s_we_q;
  logic [7:0]        s_wdata_q;
  logic [7:0]        s_mask_q;
  logic [2:0]        s_bitn_q;
  dsd_op_e           s_op_q;

  logic              acc;
  logic              is_wr;
  logic              is_bit;
  logic [4:0]        ptr_lo;
  logic [15:0]       ptr_val;
  logic [15:0]       ptr_ea;
  logic [15:0]       ptr_new;
  logic              ptr_upd;
  logic [15:0]       ea;
  logic [7:0]        bmask;
  logic [7:0]        wmask;
  logic [7:0]        wval;
  logic [7:0]        rd;
  logic [7:0]        merged;
  logic [7:0]        ctl_rd;
  logic [`DSD_SRAM_AW-1:0] s_idx;
  logic              hit_ctl;
  logic              ee_rd_go;
  logic              ee_wr_go;
  logic              internal;

  assign o_ready   = (state_q == ST_IDLE) && (stall_q == 3'h0);
  assign acc       = i_req.valid && o_ready;
  assign o_ee_busy = pe_q;
  assign is_bit    = (i_req.op == OP_BIT_SET) || (i_req.op == OP_BIT_CLR) ||
                     (i_req.op == OP_SKIP_ONE) || (i_req.op == OP_SKIP_ZERO);
  assign is_wr     = (i_req.op == OP_STORE) || (i_req.op == OP_OUT) ||
                     (i_req.op == OP_BIT_SET) || (i_req.op == OP_BIT_CLR);
  assign ptr_lo    = `DSD_PTR_X_LO + {2'b00, i_req.ptr, 1'b0};
  assign ptr_val   = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};

  dsd_ptr_unit u_ptr (
    .i_is_x    (i_req.ptr == 2'b00),
    .i_mode    (i_req.mode),
    .i_ptr     (ptr_val),
    .i_disp    (i_req.disp),
    .o_ea      (ptr_ea),
    .o_ptr_new (ptr_new),
    .o_upd     (ptr_upd)
  );

  // effective data address of the request
  always_comb begin
    ea = i_req.addr;
    unique case (i_req.op)
      OP_LOAD, OP_STORE: begin
        if (i_req.mode != AM_DIRECT) begin
          ea = ptr_ea;
        end
      end
      OP_IN, OP_OUT: begin
        ea = {10'h000, i_req.addr[5:0]} + `DSD_IO_BASE;
      end
      default: begin
        ea = {11'h000, i_req.addr[4:0]} + `DSD_IO_BASE;
      end
    endcase
  end

  // one region select per access
  always_comb begin
    o_region = '0;
    if (ea < `DSD_IO_BASE) begin
      o_region[DSD_RG_RF] = acc;
    end else if (ea < `DSD_EXT_BASE) begin
      o_region[DSD_RG_IO] = acc;
    end else if (ea < `DSD_SRAM_BASE) begin
      o_region[DSD_RG_EXT] = acc;
    end else begin
      o_region[DSD_RG_SRAM] = acc;
    end
  end
  assign s_idx = ea[`DSD_SRAM_AW-1:0];

  // bit forms write one bit only
  assign bmask = 8'h01 << i_req.bitn;
  assign wmask = is_bit ? bmask : 8'hff;
  assign wval  = is_bit ? {8{i_req.op == OP_BIT_SET}} : i_req.wdata;
  assign ctl_rd = {5'h00, mpe_q, pe_q, 1'b0};
  assign internal = (ea == `DSD_STATUS_ADR) || (ea == `DSD_GPIO0_ADR) ||
                    (ea == `DSD_EECTL_ADR) || (ea == `DSD_EEDAT_ADR) ||
                    (ea == `DSD_EEADL_ADR) || (ea == `DSD_EEADH_ADR) ||
                    (ea == `DSD_GPIO1_ADR) || (ea == `DSD_GPIO2_ADR);

  // read mux for every region but sram
  always_comb begin
    rd = i_periph_rdata;
    if (ea < `DSD_IO_BASE) begin
      rd = rf_q[ea[4:0]];
    end else if (ea == `DSD_STATUS_ADR) begin
      rd = status_q;
    end else if (ea == `DSD_GPIO0_ADR) begin
      rd = gpio_q[0];
    end else if (ea == `DSD_EECTL_ADR) begin
      rd = ctl_rd;
    end else if (ea == `DSD_EEDAT_ADR) begin
      rd = ee_data_q;
    end else if (ea == `DSD_EEADL_ADR) begin
      rd = ee_addr_q[7:0];
    end else if (ea == `DSD_EEADH_ADR) begin
      rd = {4'h0, ee_addr_q[11:8]};
    end else if (ea == `DSD_GPIO1_ADR) begin
      rd = gpio_q[1];
    end else if (ea == `DSD_GPIO2_ADR) begin
      rd = gpio_q[2];
    end
  end
  assign merged  = (rd & ~wmask) | (wval & wmask);
  assign hit_ctl = acc && is_wr && (ea == `DSD_EECTL_ADR);
  assign ee_rd_go = hit_ctl && merged[`DSD_CTL_RE] && !pe_q;
  assign ee_wr_go = hit_ctl && merged[`DSD_CTL_PE] && mpe_q &&
                    !pe_q;

  // peripheral strobe for io addresses not held here
  always_comb begin
    o_periph       = '0;
    o_periph.sel   = acc && !internal && (ea >= `DSD_IO_BASE) &&
                     (ea < `DSD_SRAM_BASE);
    o_periph.we    = is_wr;
    o_periph.addr  = ea;
    o_periph.wdata = merged;
  end

  // sequencing and stall
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      stall_q <= 3'h0;
    end else begin
      if (stall_q != 3'h0) begin
        stall_q <= stall_q - 3'h1;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (acc && o_region[DSD_RG_SRAM]) begin
            state_q <= ST_SRAM;
          end
          if (ee_rd_go) begin
            stall_q <= `DSD_EE_RD_STALL;
          end else if (ee_wr_go) begin
            stall_q <= `DSD_EE_WR_STALL;
          end
        end
        ST_SRAM: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // answer to the processor
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rsp <= '0;
    end else if (state_q == ST_SRAM) begin
      o_rsp.valid <= 1'b1;
      o_rsp.rdata <= sram_q[s_idx_q];
      o_rsp.skip  <= (s_op_q == OP_SKIP_ONE) ? sram_q[s_idx_q][s_bitn_q] :
                     (s_op_q == OP_SKIP_ZERO) && !sram_q[s_idx_q][s_bitn_q];
    end else begin
      o_rsp.valid <= acc && !o_region[DSD_RG_SRAM];
      o_rsp.rdata <= rd;
      o_rsp.skip  <= (i_req.op == OP_SKIP_ONE) ? rd[i_req.bitn] :
                     (i_req.op == OP_SKIP_ZERO) && !rd[i_req.bitn];
    end
  end

  // sram, second cycle does the array access
  always_ff @(posedge i_clk) begin
    if (acc && o_region[DSD_RG_SRAM]) begin
      s_idx_q   <= s_idx;
      s_we_q    <= is_wr;
      s_wdata_q <= wval;
      s_mask_q  <= wmask;
      s_bitn_q  <= i_req.bitn;
      s_op_q    <= i_req.op;
    end
    if ((state_q == ST_SRAM) && s_we_q) begin
      sram_q[s_idx_q] <= (sram_q[s_idx_q] & ~s_mask_q) |
                         (s_wdata_q & s_mask_q);
    end
  end

  // register file with pointer write-back
  always_ff @(posedge i_clk) begin
    if (acc && is_wr && o_region[DSD_RG_RF]) begin
      rf_q[ea[4:0]] <= merged;
    end
    if (acc && ptr_upd && ((i_req.op == OP_LOAD) || (i_req.op == OP_STORE))) begin
      rf_q[ptr_lo]         <= ptr_new[7:0];
      rf_q[ptr_lo + 5'h01] <= ptr_new[15:8];
    end
  end

  // general purpose io registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < 3; i++) begin
        gpio_q[i] <= 8'h00;
      end
    end else if (acc && is_wr) begin
      if (ea == `DSD_GPIO0_ADR) gpio_q[0] <= merged;
      if (ea == `DSD_GPIO1_ADR) gpio_q[1] <= merged;
      if (ea == `DSD_GPIO2_ADR) gpio_q[2] <= merged;
    end
  end

  // status flags, an event beats a clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status_q <= 8'h00;
    end else if (acc && is_wr && (ea == `DSD_STATUS_ADR)) begin
      status_q <= (status_q & ~(wval & wmask)) | i_status_evt;
    end else begin
      status_q <= status_q | i_status_evt;
    end
  end

  // eeprom unlock window
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mpe_q     <= 1'b0;
      mpe_cnt_q <= 3'h0;
    end else if (hit_ctl && merged[`DSD_CTL_MPE] && !merged[`DSD_CTL_PE]) begin
      mpe_q     <= 1'b1;
      mpe_cnt_q <= `DSD_MPE_WINDOW;
    end else if (ee_wr_go) begin
      mpe_q     <= 1'b0;
    end else if (mpe_q) begin
      mpe_cnt_q <= mpe_cnt_q - 3'h1;
      mpe_q     <= (mpe_cnt_q != 3'h1);
    end
  end

  // eeprom address, data and read
  always_ff @(posedge i_clk) begin
    if (acc && is_wr && !pe_q && (ea == `DSD_EEADL_ADR)) begin
      ee_addr_q[7:0] <= merged;
    end
    if (acc && is_wr && !pe_q && (ea == `DSD_EEADH_ADR)) begin
      ee_addr_q[11:8] <= merged[3:0];
    end
    if (ee_rd_go) begin
      ee_data_q <= ee_mem_q[ee_addr_q[`DSD_EE_AW-1:0]];
    end else if (acc && is_wr && (ea == `DSD_EEDAT_ADR)) begin
      ee_data_q <= merged;
    end
  end

  // self-timed write, a running write ignores reset
  always_ff @(posedge i_clk) begin
    if (pe_q) begin
      wr_cnt_q <= wr_cnt_q - 20'h00001;
      if (wr_cnt_q == 20'h00001) begin
        pe_q <= 1'b0;
        ee_mem_q[wr_addr_q] <= wr_data_q;
      end
    end else if (i_srst) begin
      pe_q     <= 1'b0;
      wr_cnt_q <= 20'h00000;
    end else if (ee_wr_go) begin
      pe_q      <= 1'b1;
      wr_cnt_q  <= 20'(EE_WR_CYCLES);
      wr_addr_q <= ee_addr_q[`DSD_EE_AW-1:0];
      wr_data_q <= ee_data_q;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence ee_rd_s;
    acc && ee_rd_go;
  endsequence
  sequence stall_four_s;
    !o_ready [*4] ##1 o_ready;
  endsequence

  region_onehot_a: assert property (acc |-> $onehot(o_region))
    else $error("region select not one-hot");
  sram_two_cyc_a: assert property (acc && o_region[DSD_RG_SRAM] |=>
    !o_rsp.valid ##1 o_rsp.valid) else $error("sram answer not in two");
  io_ack_next_a: assert property (acc && !o_region[DSD_RG_SRAM] |=>
    o_rsp.valid) else $error("answer missing");
  ee_rd_stall_a: assert property (ee_rd_s |=> stall_four_s)
    else $error("eeprom read stall wrong");
  ee_wr_stall_a: assert property (ee_wr_go |=>
    !o_ready [*2] ##1 o_ready) else $error("eeprom write stall wrong");
  mpe_timeout_a: assert property ($rose(mpe_q) |-> ##[1:4] !mpe_q)
    else $error("unlock did not time out");
  strobe_unlock_a: assert property ($rose(pe_q) |-> $past(mpe_q))
    else $error("write started without unlock");
  strobe_clear_a: assert property (pe_q && wr_cnt_q == 20'h00001 |=>
    !pe_q && !o_ee_busy) else $error("strobe not cleared");
  flag_set_wins_a: assert property (i_status_evt[0] |=> status_q[0])
    else $error("status event lost");
  bit_only_a: assert property (acc && is_bit && is_wr &&
    ea == `DSD_GPIO0_ADR |=> ((gpio_q[0] ^ $past(gpio_q[0])) &
    ~$past(bmask)) == 8'h00) else $error("bit write touched others");
  in_not_ext_a: assert property (acc && (i_req.op == OP_IN ||
    i_req.op == OP_OUT) |-> !o_region[DSD_RG_EXT])
    else $error("port access reached extended io");
endmodule : dsd_decoder

// ===== hdl/dsd_cfg.svh
// Purpose: constants of the data space decoder
// Assumes: 100 MHz clock, smallest memory variant
// Notes:   shared by the decoder and the test bench
// What this block does
// - regfile 32, io 64, ext io 160, sram
// - sram sits directly above extended io
// - extended io only by loads and stores
// - io ports 0x00-0x3F, data address plus 0x20
// - bit access only on ports 0x00-0x1F
// - bit set/clear writes only addressed bit
// - all status flags clear on writing one
// - sram access takes two cycles
// - eeprom read stalls four, write two
// - eeprom write in progress survives reset
// - displacement reaches 63 above y or z
// - pre-decrement before, post-increment after access
// - r26 to r31 are the pointer pairs
// - every region reachable in all modes
// - eeprom is separate byte-wide space
// - eeprom write self-timed, busy pollable
// - all io reachable by loads and stores
// - three general purpose io registers
// - strobe within four cycles of enable
// - strobe clears when write time elapses
`ifndef DSD_CFG_SVH
`define DSD_CFG_SVH
`define DSD_IO_BASE      16'h0020
`define DSD_EXT_BASE     16'h0060
`define DSD_SRAM_BASE    16'h0100
`define DSD_SRAM_AW      10
`define DSD_SRAM_BYTES   1024
`define DSD_EE_AW        9
`define DSD_EE_BYTES     512
`define DSD_PTR_X_LO     5'h1a
`define DSD_STATUS_ADR   16'h003c
`define DSD_GPIO0_ADR    16'h003e
`define DSD_EECTL_ADR    16'h003f
`define DSD_EEDAT_ADR    16'h0040
`define DSD_EEADL_ADR    16'h0041
`define DSD_EEADH_ADR    16'h0042
`define DSD_GPIO1_ADR    16'h004a
`define DSD_GPIO2_ADR    16'h004b
`define DSD_CTL_RE       0
`define DSD_CTL_PE       1
`define DSD_CTL_MPE      2
`define DSD_EE_RD_STALL  3'h4
`define DSD_EE_WR_STALL  3'h2
`define DSD_MPE_WINDOW   3'h4
`define DSD_CLK_NS       10
`define DSD_EE_WR_NS     3300000
`define DSD_EE_WR_CYC    (`DSD_EE_WR_NS / `DSD_CLK_NS)
`endif

// ===== hdl/dsd_pkg.sv
// Purpose: types of the data space decoder
// Assumes: constants come from dsd_cfg.svh
// Notes:   request and answer travel as packed structs
package dsd_pkg;
  typedef enum logic [2:0] {
    OP_LOAD, OP_STORE, OP_IN, OP_OUT,
    OP_BIT_SET, OP_BIT_CLR, OP_SKIP_ONE, OP_SKIP_ZERO
  } dsd_op_e;
  typedef enum logic [2:0] {
    AM_DIRECT, AM_IND, AM_DISP, AM_PREDEC, AM_POSTINC
  } dsd_mode_e;
  typedef struct packed {
    logic        valid;
    dsd_op_e     op;
    dsd_mode_e   mode;
    logic [1:0]  ptr;
    logic [5:0]  disp;
    logic [15:0] addr;
    logic [2:0]  bitn;
    logic [7:0]  wdata;
  } dsd_req_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       skip;
  } dsd_rsp_s;
  typedef struct packed {
    logic        sel;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dsd_periph_s;
  typedef logic [3:0] dsd_region_t;
  localparam int DSD_RG_RF   = 0;
  localparam int DSD_RG_IO   = 1;
  localparam int DSD_RG_EXT  = 2;
  localparam int DSD_RG_SRAM = 3;
endpackage : dsd_pkg

// ===== hdl/dsd_ptr_unit.sv
// Purpose: effective address and pointer update
// Assumes: pointer pair value read from the register file
// Notes:   x has no displacement form, it is ignored there
`timescale 1ns/1ps
module dsd_ptr_unit (
  input  wire logic              i_is_x,
  input  dsd_pkg::dsd_mode_e     i_mode,
  input  wire logic [15:0]       i_ptr,
  input  wire logic [5:0]        i_disp,
  output logic      [15:0]       o_ea,
  output logic      [15:0]       o_ptr_new,
  output logic                   o_upd
);
  import dsd_pkg::*;
  always_comb begin
    o_ea      = i_ptr;
    o_ptr_new = i_ptr;
    o_upd     = 1'b0;
    unique case (i_mode)
      AM_DISP: begin
        if (!i_is_x) begin
          o_ea = i_ptr + {10'h000, i_disp};
        end
      end
      AM_PREDEC: begin
        o_ptr_new = i_ptr - 16'h0001;
        o_ea      = o_ptr_new;
        o_upd     = 1'b1;
      end
      AM_POSTINC: begin
        o_ptr_new = i_ptr + 16'h0001;
        o_upd     = 1'b1;
      end
      default: begin
        o_ea = i_ptr;
      end
    endcase
  end
endmodule : dsd_ptr_unit

// ===== verif/dsd_periph_model.sv
// Purpose: peripheral registers behind the io windows
// Assumes: read data answers the strobe at once
// Notes:   unselected read data toggles every cycle
`timescale 1ns/1ps
module dsd_periph_model (
  input  wire logic            i_clk,
  input  dsd_pkg::dsd_periph_s i_periph,
  output logic [7:0]           o_rdata
);
  import dsd_pkg::*;
  logic [7:0] regs_q [256];
  logic [7:0] junk_q;
  initial begin
    junk_q = 8'h5a;
    for (int i = 0; i < 256; i++) regs_q[i] = 8'h00;
  end
  always @(posedge i_clk) begin
    junk_q <= ~junk_q;
    if (i_periph.sel && i_periph.we) begin
      regs_q[i_periph.addr[7:0]] <= i_periph.wdata;
    end
  end
  assign o_rdata = i_periph.sel ? regs_q[i_periph.addr[7:0]] : junk_q;
endmodule : dsd_periph_model

// ===== verif/data_space_decoder_test.sv
// Purpose: self-checking bench for the data space decoder
// Assumes: short eeprom write time
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`include "dsd_cfg.svh"
module data_space_decoder_test;
  import dsd_pkg::*;
  localparam int EE_CYC = 20;
  logic        clk;
  logic        srst;
  dsd_req_s    req;
  logic        rdy;
  dsd_rsp_s    rsp;
  dsd_region_t rgn;
  dsd_periph_s per;
  logic [7:0]  prd;
  logic [7:0]  evt;
  logic        busy;
  int          n_mismatch;
  int          tests_run;
  logic [7:0]  g_rd;
  logic [7:0]  g_lat;
  logic [7:0]  g_stl;
  logic        g_sk;
  dsd_region_t g_rg;
  dsd_periph_s g_ps;
  logic [15:0] adr_tab [8];

  dsd_decoder #(.EE_WR_CYCLES(EE_CYC)) u_dut (
    .i_clk(clk), .i_srst(srst), .i_req(req), .o_ready(rdy),
    .o_rsp(rsp), .o_region(rgn), .o_periph(per),
    .i_periph_rdata(prd), .i_status_evt(evt), .o_ee_busy(busy));
  dsd_periph_model u_per (.i_clk(clk), .i_periph(per), .o_rdata(prd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic xfer(input dsd_op_e op, input dsd_mode_e md,
      input logic [1:0] pt, input logic [5:0] dp, input logic [15:0] ad,
      input logic [2:0] bn, input logic [7:0] wd);
    int k;
    k = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    req = '{1'b1, op, md, pt, dp, ad, bn, wd};
    #1;
    g_rg = rgn;
    g_ps = per;
    g_lat = 8'h00;
    g_stl = 8'h00;
    g_rd  = 8'hxx;
    g_sk  = 1'bx;
    for (k = 1; k <= 8; k++) begin
      @(negedge clk);
      if (k == 1) req.valid = 1'b0;
      if (rsp.valid === 1'b1 && g_lat == 8'h00) begin
        g_lat = 8'(k);
        g_rd = rsp.rdata;
        g_sk = rsp.skip;
      end
      if (rdy !== 1'b1) g_stl++;
      else if (g_lat != 8'h00) break;
    end
  endtask : xfer

  task automatic st(input logic [15:0] a, input logic [7:0] d);
    xfer(OP_STORE, AM_DIRECT, 2'h0, 6'h00, a, 3'h0, d);
  endtask : st

  task automatic ld(input logic [15:0] a);
    xfer(OP_LOAD, AM_DIRECT, 2'h0, 6'h00, a, 3'h0, 8'h00);
  endtask : ld

  task automatic bop(input dsd_op_e op, input logic [15:0] a,
                     input logic [2:0] b);
    xfer(op, AM_DIRECT, 2'h0, 6'h00, a, b, 8'h00);
  endtask : bop

  task automatic sc_regions();
    logic [7:0] v;
    logic [7:0] e;
    adr_tab = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
                16'h0060, 16'h00ff, 16'h0100, 16'h04ff};
    for (int i = 0; i < 8; i++) begin
      v = adr_tab[i][7:0] + 8'h11;
      e = 8'h00;
      e[6:3] = 4'h1 << (i / 2);
      e[2] = (i > 1 && i < 6);
      e[1:0] = (i > 5) ? 2'h2 : 2'h1;
      st(adr_tab[i], v);
      ld(adr_tab[i]);
      chk({1'b0, g_rg, g_ps.sel, g_lat[1:0]}, e, "region");
      chk(g_rd, v, "data");
      chk({7'h00, g_sk}, 8'h00, "no skip");
    end
  endtask : sc_regions

  task automatic sc_ports();
    xfer(OP_OUT, AM_DIRECT, 2'h0, 6'h00, 16'h001e, 3'h0, 8'h81);
    ld(`DSD_GPIO0_ADR);
    chk(g_rd, 8'h81, "out");
    xfer(OP_IN, AM_DIRECT, 2'h0, 6'h00, 16'h003f, 3'h0, 8'h00);
    chk({g_rg, 4'h0}, 8'h20, "in region");
    chk(g_ps.addr[7:0], 8'h5f, "in addr");
    chk(g_rd, 8'h70, "in data");
  endtask : sc_ports

  task automatic sc_b2b();
    @(negedge clk);
    req = '{1'b1, OP_STORE, AM_DIRECT, 2'h0, 6'h00,
            `DSD_GPIO2_ADR, 3'h0, 8'h96};
    @(negedge clk);
    chk({rdy, rsp.valid, 6'h00}, 8'hc0, "first");
    req.op = OP_LOAD;
    @(negedge clk);
    req.valid = 1'b0;
    chk({rsp.valid, rsp.rdata[6:0]}, 8'h96, "second");
  endtask : sc_b2b

  task automatic sc_bits();
    bop(OP_BIT_SET, 16'h001e, 3'h3);
    ld(`DSD_GPIO0_ADR);
    chk(g_rd, 8'h89, "bit set");
    bop(OP_BIT_CLR, 16'h001e, 3'h0);
    ld(`DSD_GPIO0_ADR);
    chk(g_rd, 8'h88, "bit clear");
    bop(OP_SKIP_ONE, 16'h001e, 3'h3);
    chk({7'h00, g_sk}, 8'h01, "skip one");
    bop(OP_SKIP_ZERO, 16'h001e, 3'h3);
    chk({7'h00, g_sk}, 8'h00, "skip zero");
    @(negedge clk);
    evt = 8'h05;
    @(negedge clk);
    evt = 8'h00;
    bop(OP_BIT_SET, 16'h001c, 3'h0);
    ld(`DSD_STATUS_ADR);
    chk(g_rd, 8'h04, "flag kept");
    st(`DSD_STATUS_ADR, 8'h04);
    ld(`DSD_STATUS_ADR);
    chk(g_rd, 8'h00, "flag clear");
    st(16'h0025, 8'h40);
    bop(OP_BIT_SET, 16'h0005, 3'h1);
    chk({g_ps.we, g_ps.wdata[6:0]}, 8'hc2, "merge");
  endtask : sc_bits

  task automatic sc_ptr();
    st(16'h001c, 8'h00);
    st(16'h001d, 8'h02);
    xfer(OP_STORE, AM_DISP, 2'h1, 6'h3f, 16'h0000, 3'h0, 8'h77);
    ld(16'h023f);
    chk(g_rd, 8'h77, "disp");
    st(16'h001a, 8'h10);
    st(16'h001b, 8'h01);
    xfer(OP_STORE, AM_POSTINC, 2'h0, 6'h00, 16'h0000, 3'h0, 8'h11);
    ld(16'h0110);
    chk(g_rd, 8'h11, "postinc data");
    ld(16'h001a);
    chk(g_rd, 8'h11, "postinc ptr");
    st(16'h001e, 8'h20);
    st(16'h001f, 8'h01);
    xfer(OP_STORE, AM_PREDEC, 2'h2, 6'h00, 16'h0000, 3'h0, 8'h22);
    ld(16'h011f);
    chk(g_rd, 8'h22, "predec data");
    ld(16'h001e);
    chk(g_rd, 8'h1f, "predec ptr");
    st(16'h001e, 8'h3e);
    st(16'h001f, 8'h00);
    xfer(OP_LOAD, AM_IND, 2'h2, 6'h00, 16'h0000, 3'h0, 8'h00);
    chk({g_rg, g_rd[3:0]}, 8'h28, "indirect io");
  endtask : sc_ptr

  task automatic ee_adr(input logic [8:0] a);
    st(`DSD_EEADL_ADR, a[7:0]);
    st(`DSD_EEADH_ADR, {7'h00, a[8]});
  endtask : ee_adr

  task automatic ee_wr(input logic [8:0] a, input logic [7:0] d);
    ee_adr(a);
    st(`DSD_EEDAT_ADR, d);
    st(`DSD_EECTL_ADR, 8'h04);
    st(`DSD_EECTL_ADR, 8'h06);
  endtask : ee_wr

  task automatic ee_rd(input logic [8:0] a, input logic [7:0] d);
    ee_adr(a);
    st(`DSD_EECTL_ADR, 8'h01);
    chk(g_stl, 8'h04, "read stall");
    ld(`DSD_EEDAT_ADR);
    chk(g_rd, d, "ee data");
  endtask : ee_rd

  task automatic ee_wait(output int n);
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask : ee_wait

  task automatic sc_eeprom();
    int n;
    ee_wr(9'h105, 8'h11);
    chk(g_stl, 8'h02, "write stall");
    chk({7'h00, busy}, 8'h01, "busy");
    ld(`DSD_EECTL_ADR);
    chk(g_rd & 8'h02, 8'h02, "strobe held");
    ee_wait(n);
    chk(8'(n > EE_CYC - 8 && n <= EE_CYC), 8'h01, "wr time");
    ld(`DSD_EECTL_ADR);
    chk(g_rd, 8'h00, "strobe off");
    st(`DSD_EEDAT_ADR, 8'hc3);
    st(`DSD_EECTL_ADR, 8'h02);
    chk({7'h00, busy}, 8'h00, "no unlock");
    st(`DSD_EECTL_ADR, 8'h04);
    ld(`DSD_EECTL_ADR);
    chk(g_rd, 8'h04, "unlock");
    repeat (6) @(negedge clk);
    ld(`DSD_EECTL_ADR);
    chk(g_rd, 8'h00, "unlock gone");
    st(`DSD_EECTL_ADR, 8'h02);
    chk({7'h00, busy}, 8'h00, "late strobe");
    ee_rd(9'h105, 8'h11);
    ee_wr(9'h0a0, 8'h5c);
    repeat (3) @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk({7'h00, busy}, 8'h01, "busy in reset");
    ee_wait(n);
    ee_rd(9'h0a0, 8'h5c);
  endtask : sc_eeprom

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    srst = 1'b1;
    req = '0;
    evt = 8'h00;
    repeat (16) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    sc_regions();
    sc_ports();
    sc_b2b();
    sc_bits();
    sc_ptr();
    sc_eeprom();
    complete_run();
  end
endmodule : data_space_decoder_test
